// ===== rtl/embi_bus.v
`timescale 1ns/1ps
`default_nettype none
`include "embi_map.vh"
// What this block does
// - port zero carries low address then data
// - port two drives high address byte
// - separate 64K program and data spaces
// - port three function needs latch one
// - bits 0,1 serial receive, transmit/clock
// - bits 2,3 interrupt and counter gate
// - bits 4,5 counter count inputs
// - bit 6 active-low data write strobe
// - bit 7 active-low data read strobe
// - high reset pin resets the device
// - latch strobe every six periods, skipped data
// - fetch strobe every six periods externally
// - fetch strobe high for internal execution
// - select high: internal below 4096
// - select low: every fetch external
module embi_bus #(
	parameter AW = `EMBI_ADDR_W
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire reset_standby_pin,
	input wire fetch_select,
	input wire [AW-1:0] fetch_addr,
	input wire fetch_req,
	output wire fetch_ready,
	output reg [7:0] fetch_data,
	output reg fetch_valid,
	output reg fetch_internal,
	input wire data_req,
	input wire data_we,
	input wire [AW-1:0] data_addr,
	input wire [7:0] data_wdata,
	output reg [7:0] data_rdata,
	output reg data_done,
	output wire data_ready,
	output wire core_reset,
	input wire [7:0] port_three_latch,
	input wire serial_sync_mode,
	input wire serial_tx_data,
	input wire serial_shift_clk,
	input wire serial_data_out,
	input wire serial_data_oe,
	output wire serial_rx_data,
	output wire ext_irq_zero_n,
	output wire ext_irq_one_n,
	output wire count_gate_zero,
	output wire count_gate_one,
	output wire count_in_zero,
	output wire count_in_one,
	output wire [7:0] port_three_alt_func_in_q,
	input wire [7:0] port_three_alt_func_in,
	output reg [7:0] port_three_alt_func_out,
	output reg [7:0] port_three_alt_func_oe,
	input wire [7:0] port_zero_addr_data_in,
	output reg [7:0] port_zero_addr_data_out,
	output reg [7:0] port_zero_addr_data_oe,
	output reg [7:0] port_two_high_addr,
	output reg addr_latch_strobe,
	output reg prog_fetch_strobe_n
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] ST_FETCH = 3'b001;
	localparam [2:0] ST_DATA = 3'b010;
	localparam [2:0] ST_RESET = 3'b100;
	localparam [3:0] C_SLOT_LAST = `EMBI_OSC_PER_ALE - 1;
	localparam [3:0] C_ALE_LAST = `EMBI_ALE_END - 1;
	localparam [3:0] C_STRB_FIRST = `EMBI_STRB_BEG - 1;
	localparam [3:0] C_DATA_LAST = `EMBI_DATA_CYCLES - 1;
	localparam [3:0] C_DSTRB_FIRST = `EMBI_DATA_STRB_BEG - 1;
	localparam [3:0] C_DSTRB_LAST = `EMBI_DATA_STRB_END - 1;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [3:0] cnt_r;
	reg [3:0] cnt_nxt;
	reg ext_fetch_r;
	reg data_we_r;
	reg [7:0] wdata_r;
	reg wr_n_r;
	reg rd_n_r;
	wire rst_q;
	wire sel_q;
	wire [7:0] p3_q;
	wire [7:0] p0_q;
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	embi_sync #(.W(1), .INIT(1'b1)) u_rst (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.d(reset_standby_pin),
		.q(rst_q)
	);
	embi_sync #(.W(1), .INIT(1'b0)) u_sel (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.d(fetch_select),
		.q(sel_q)
	);
	embi_sync #(.W(8), .INIT(8'hFF)) u_p3 (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.d(port_three_alt_func_in),
		.q(p3_q)
	);
	// memories answer strobes launched on this clock, so no filter:
	// a three-stage filter would lag past the end of the strobe
	assign p0_q = port_zero_addr_data_in;
	assign core_reset = rst_q;
	// ----------------------------------------
	// fetch decode
	// ----------------------------------------
	function is_external;
		input sel;
		input [AW-1:0] a;
		begin
			is_external = !sel || ({1'b0, a} >= `EMBI_INT_ROM_LIMIT);
		end
	endfunction
	// ----------------------------------------
	// port three alternate functions
	// ----------------------------------------
	// a zero latch forces the pin low and blocks the function
	assign port_three_alt_func_in_q = p3_q & port_three_latch;
	assign serial_rx_data = port_three_alt_func_in_q[`EMBI_P3_RXD];
	assign ext_irq_zero_n = port_three_alt_func_in_q[`EMBI_P3_IRQ0];
	assign ext_irq_one_n = port_three_alt_func_in_q[`EMBI_P3_IRQ1];
	assign count_gate_zero = port_three_alt_func_in_q[`EMBI_P3_IRQ0];
	assign count_gate_one = port_three_alt_func_in_q[`EMBI_P3_IRQ1];
	assign count_in_zero = port_three_alt_func_in_q[`EMBI_P3_CNT0];
	assign count_in_one = port_three_alt_func_in_q[`EMBI_P3_CNT1];
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_three_alt_func_out <= `EMBI_P3_RST;
			port_three_alt_func_oe <= 8'h00;
		end else if (ce) begin
			port_three_alt_func_out <= port_three_latch;
			port_three_alt_func_oe <= ~port_three_latch;
			if (serial_sync_mode) begin
				port_three_alt_func_out[`EMBI_P3_RXD] <= serial_data_out & port_three_latch[0];
				port_three_alt_func_oe[`EMBI_P3_RXD] <= serial_data_oe | ~port_three_latch[0];
				port_three_alt_func_out[`EMBI_P3_TXD] <= serial_shift_clk & port_three_latch[1];
			end else begin
				port_three_alt_func_out[`EMBI_P3_TXD] <= serial_tx_data & port_three_latch[1];
			end
			port_three_alt_func_oe[`EMBI_P3_TXD] <= 1'b1;
			port_three_alt_func_out[`EMBI_P3_WR] <= wr_n_r & port_three_latch[6];
			port_three_alt_func_oe[`EMBI_P3_WR] <= 1'b1;
			port_three_alt_func_out[`EMBI_P3_RD] <= rd_n_r & port_three_latch[7];
			port_three_alt_func_oe[`EMBI_P3_RD] <= 1'b1;
		end
	end
	// ----------------------------------------
	// machine cycle sequencer
	// ----------------------------------------
	assign fetch_ready = (state_r == ST_FETCH) && (cnt_r == 4'h0) && !data_req && !rst_q;
	assign data_ready = (state_r == ST_FETCH) && (cnt_r == 4'h0) && !rst_q;
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 4'h1;
		case (state_r)
			ST_RESET: begin
				cnt_nxt = 4'h0;
				if (!rst_q) begin
					state_nxt = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (cnt_r == 4'h0 && data_req) begin
					state_nxt = ST_DATA;
				end else if (cnt_r == C_SLOT_LAST) begin
					cnt_nxt = 4'h0;
				end
			end
			ST_DATA: begin
				if (cnt_r == C_DATA_LAST) begin
					cnt_nxt = 4'h0;
					state_nxt = ST_FETCH;
				end
			end
			default: begin
				state_nxt = ST_RESET;
				cnt_nxt = 4'h0;
			end
		endcase
		if (rst_q) begin
			state_nxt = ST_RESET;
			cnt_nxt = 4'h0;
		end
	end
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_RESET;
			cnt_r <= 4'h0;
			ext_fetch_r <= 1'b0;
			data_we_r <= 1'b0;
			wdata_r <= 8'h00;
			wr_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			fetch_data <= 8'h00;
			fetch_valid <= 1'b0;
			fetch_internal <= 1'b0;
			data_rdata <= 8'h00;
			data_done <= 1'b0;
			port_zero_addr_data_out <= 8'h00;
			port_zero_addr_data_oe <= 8'h00;
			port_two_high_addr <= 8'h00;
			addr_latch_strobe <= 1'b0;
			prog_fetch_strobe_n <= 1'b1;
		end else if (ce) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			fetch_valid <= 1'b0;
			data_done <= 1'b0;
			if (state_nxt == ST_RESET) begin
				addr_latch_strobe <= 1'b0;
				prog_fetch_strobe_n <= 1'b1;
				wr_n_r <= 1'b1;
				rd_n_r <= 1'b1;
				port_zero_addr_data_oe <= 8'h00;
			end else if (state_r == ST_FETCH && cnt_r == 4'h0 && data_req) begin
				// latch pulse of a data cycle carries the data address
				data_we_r <= data_we;
				wdata_r <= data_wdata;
				port_two_high_addr <= data_addr[15:8];
				port_zero_addr_data_out <= data_addr[7:0];
				port_zero_addr_data_oe <= 8'hFF;
				addr_latch_strobe <= 1'b1;
				prog_fetch_strobe_n <= 1'b1;
			end else if (state_r == ST_FETCH && cnt_r == 4'h0) begin
				ext_fetch_r <= is_external(sel_q, fetch_addr);
				fetch_internal <= !is_external(sel_q, fetch_addr);
				port_two_high_addr <= fetch_addr[15:8];
				port_zero_addr_data_out <= fetch_addr[7:0];
				port_zero_addr_data_oe <= 8'hFF;
				addr_latch_strobe <= 1'b1;
			end else if (state_r == ST_FETCH) begin
				if (cnt_r == C_ALE_LAST) begin
					addr_latch_strobe <= 1'b0;
				end
				if (cnt_r == C_STRB_FIRST) begin
					port_zero_addr_data_oe <= 8'h00;
					prog_fetch_strobe_n <= !ext_fetch_r;
				end
				if (cnt_r == C_SLOT_LAST) begin
					prog_fetch_strobe_n <= 1'b1;
					fetch_valid <= fetch_req;
					fetch_data <= p0_q;
				end
			end else if (state_r == ST_DATA) begin
				// no fetch strobe and no latch pulse after the opening one for the whole data cycle
				if (cnt_r == C_ALE_LAST) begin
					addr_latch_strobe <= 1'b0;
				end
				if (cnt_r == C_STRB_FIRST) begin
					port_zero_addr_data_out <= wdata_r;
					port_zero_addr_data_oe <= {8{data_we_r}};
				end
				if (cnt_r == C_DSTRB_FIRST) begin
					wr_n_r <= !data_we_r;
					rd_n_r <= data_we_r;
				end
				if (cnt_r == C_DSTRB_LAST) begin
					wr_n_r <= 1'b1;
					rd_n_r <= 1'b1;
					data_rdata <= data_we_r ? data_rdata : p0_q;
					data_done <= 1'b1;
				end
				if (cnt_r == C_DATA_LAST) begin
					port_zero_addr_data_oe <= 8'h00;
				end
			end
		end
	end
endmodule // embi_bus
`default_nettype wire

// ===== rtl/embi_map.vh
`ifndef EMBI_MAP_VH
`define EMBI_MAP_VH
// ----------------------------------------
// timing, in oscillator periods (one mclk per period)
// ----------------------------------------
`define EMBI_OSC_PER_ALE 6
`define EMBI_ALE_END 2
`define EMBI_STRB_BEG 3
`define EMBI_DATA_CYCLES 12
`define EMBI_DATA_STRB_BEG 4
`define EMBI_DATA_STRB_END 10
// ----------------------------------------
// fetch split and widths
// ----------------------------------------
`define EMBI_INT_ROM_LIMIT 17'h01000
`define EMBI_ADDR_W 16
// ----------------------------------------
// port three bit positions
// ----------------------------------------
`define EMBI_P3_RXD 0
`define EMBI_P3_TXD 1
`define EMBI_P3_IRQ0 2
`define EMBI_P3_IRQ1 3
`define EMBI_P3_CNT0 4
`define EMBI_P3_CNT1 5
`define EMBI_P3_WR 6
`define EMBI_P3_RD 7
`define EMBI_P3_RST 8'hFF
`endif

// ===== rtl/embi_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// three-stage synchroniser, change accepted when stages two and three agree
// ----------------------------------------
module embi_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	reg [W-1:0] q_r;
	genvar i;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else if (ce) begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					q_r[i] <= INIT[i];
				end else if (ce && (s2_r[i] == s3_r[i])) begin
					q_r[i] <= s3_r[i];
				end
			end
		end
	endgenerate
	assign q = q_r;
endmodule // embi_sync
`default_nettype wire

// ===== verification/embi_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module embi_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fetch_select,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_ready,
	input wire logic data_req,
	input wire logic data_we,
	input wire logic [15:0] data_addr,
	input wire logic data_ready,
	input wire logic core_reset,
	input wire logic [7:0] port_three_alt_func_out,
	input wire logic [7:0] port_zero_addr_data_out,
	input wire logic [7:0] port_zero_addr_data_oe,
	input wire logic [7:0] port_two_high_addr,
	input wire logic addr_latch_strobe,
	input wire logic prog_fetch_strobe_n
);
	// ------
	// take events
	// ------
	wire tk_f = fetch_ready && !data_req;
	wire tk_x = tk_f && (!fetch_select || fetch_addr >= 16'h1000);
	wire tk_d = data_ready && data_req;
	wire ale = addr_latch_strobe;
	wire ps = prog_fetch_strobe_n;
	wire rd = port_three_alt_func_out[7];
	wire wr = port_three_alt_func_out[6];
	wire [15:0] bus_a = {port_two_high_addr, port_zero_addr_data_out};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_fetch_addr_out: assert property (tk_x |=> bus_a == $past(fetch_addr)
		&& port_zero_addr_data_oe == 8'hFF) else $error("fetch address not on ports");
	a_data_addr_out: assert property (tk_d |=> bus_a == $past(data_addr))
		else $error("data address not on ports");
	a_ale_fetch: assert property (tk_f |=> ale ##1 !ale)
		else $error("latch strobe wrong in fetch");
	a_ale_data_skip: assert property (tk_d |=> ale ##1 !ale[*8])
		else $error("latch strobe not skipped");
	a_fetch_strobe_ext: assert property (tk_x |-> ##3 !ps[*3] ##1 ps)
		else $error("fetch strobe wrong");
	a_fetch_strobe_int: assert property (tk_f && !tk_x |=> ps[*6])
		else $error("fetch strobe in internal fetch");
	a_read_strobe: assert property (tk_d && !data_we |-> ##5 !rd[*6] ##1 rd)
		else $error("read strobe wrong");
	a_write_strobe: assert property (tk_d && data_we |-> ##5 !wr[*6] ##1 wr)
		else $error("write strobe wrong");
	a_strobe_excl: assert property ($onehot0({!ps, !rd, !wr}))
		else $error("strobes overlap");
	a_bus_release: assert property (!ps || !rd |-> port_zero_addr_data_oe == 8'h00)
		else $error("port zero driven under memory");
	a_reset_hold: assert property (core_reset |-> !fetch_ready && !data_ready)
		else $error("request taken in reset");
	cover property (tk_x);
	cover property (tk_f && !tk_x);
	cover property (tk_d && data_we);
	cover property (tk_d && !data_we);
endmodule // embi_chk
bind embi_bus embi_chk chk_u (.mclk, .rst_n, .fetch_select, .fetch_addr, .fetch_ready,
	.data_req, .data_we, .data_addr, .data_ready, .core_reset, .port_three_alt_func_out,
	.port_zero_addr_data_out, .port_zero_addr_data_oe, .port_two_high_addr,
	.addr_latch_strobe, .prog_fetch_strobe_n);
`default_nettype wire

// ===== verification/embi_mem.sv
`timescale 1ns/1ps
`default_nettype none
module embi_mem (
	input wire logic mclk,
	input wire logic ale,
	input wire logic prog_fetch_strobe_n_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] p2,
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p0_oe,
	output logic [7:0] p0_in
);
	// ------
	// latch, memories, bus
	// ------
	logic [7:0] lo_r, last_r, mv;
	logic [7:0] pat_r = 8'h3C;
	logic [1:0] hold_r = 2'h0;
	logic wr_q = 1'b1;
	logic [7:0] dm [0:65535];
	wire [15:0] a = {p2, lo_r};
	wire on = !prog_fetch_strobe_n_n || !rd_n;
	always @(negedge ale) lo_r = p0_out;
	assign mv = !prog_fetch_strobe_n_n ? (a[7:0] ^ a[15:8] ^ 8'hA5) : dm[a];
	always @(posedge mclk) begin
		if (on) begin
			hold_r <= 2'h3;
			last_r <= mv;
		end else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
		wr_q <= wr_n;
		if (wr_n && !wr_q) dm[a] <= p0_out;
		pat_r <= pat_r + 8'h5B;
	end
	// released bus holds the last byte for three clocks, then shows a moving pattern
	wire [7:0] drv = on ? mv : (hold_r != 2'h0 ? last_r : pat_r);
	assign p0_in = (p0_out & p0_oe) | (drv & ~p0_oe);
endmodule // embi_mem
`default_nettype wire

// ===== verification/embi_bus_tb.sv
`timescale 1ns/1ps
`default_nettype none
module embi_bus_tb;
	logic mclk = 0, rst_n = 0, ce = 1, reset_standby_pin = 1, fetch_select = 0, fetch_req = 1;
	logic data_req = 0, data_we = 0, serial_sync_mode = 0, serial_tx_data = 0;
	logic serial_shift_clk = 0, serial_data_out = 0, serial_data_oe = 0;
	logic [15:0] fetch_addr = 16'h0000, data_addr = 16'h0000;
	logic [7:0] data_wdata = 8'h00, port_three_latch = 8'hFF, port_three_alt_func_in = 8'hFF;
	wire [7:0] port_zero_addr_data_in, fetch_data, data_rdata, port_three_alt_func_in_q;
	wire [7:0] port_three_alt_func_out, port_three_alt_func_oe, port_zero_addr_data_out;
	wire [7:0] port_zero_addr_data_oe, port_two_high_addr;
	wire fetch_ready, fetch_valid, fetch_internal, data_done, data_ready, core_reset;
	wire serial_rx_data, ext_irq_zero_n, ext_irq_one_n, count_gate_zero, count_gate_one;
	wire count_in_zero, count_in_one, addr_latch_strobe, prog_fetch_strobe_n;
	int n_fail = 0, tests_run = 0, k;
	logic [31:0] seed = 32'h1DF74FED;
	logic [9:0] exp_q [$];
	logic [9:0] e;
	logic [7:0] sh [logic [15:0]];
	logic [7:0] p;
	logic [15:0] ad;
	always #4 mclk = ~mclk;
	embi_bus dut_u (.*);
	embi_mem mem_u (.mclk, .ale(addr_latch_strobe), .prog_fetch_strobe_n_n(prog_fetch_strobe_n),
		.rd_n(port_three_alt_func_out[7]), .wr_n(port_three_alt_func_out[6]),
		.p2(port_two_high_addr), .p0_out(port_zero_addr_data_out),
		.p0_oe(port_zero_addr_data_oe), .p0_in(port_zero_addr_data_in));
	// ------
	// helpers
	// ------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one request per sequencer slot; fetch_req stays high so every slot is noted
	task automatic take(input logic [15:0] fa, input logic dr, input logic w,
			input logic [15:0] da, input logic [7:0] wd);
		int i;
		fetch_addr <= fa;
		data_req <= dr;
		data_we <= w;
		data_addr <= da;
		data_wdata <= wd;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (i < 40 && fetch_ready !== 1'b1 && data_ready !== 1'b1);
		if (i == 40) begin
			n_fail++;
			stop_test();
		end
		if (dr && data_ready === 1'b1) begin
			if (w) sh[da] = wd;
			exp_q.push_back({w ? 2'd3 : 2'd2, w ? 8'h00 : sh[da]});
		end else if (fetch_select && fa < 16'h1000) exp_q.push_back(10'h000);
		else exp_q.push_back({2'd1, fa[7:0] ^ fa[15:8] ^ 8'hA5});
	endtask
	// ------
	// result watcher
	// ------
	always @(posedge mclk) begin
		if (fetch_valid === 1'b1 || data_done === 1'b1) begin
			if (exp_q.size() == 0) chk(8'hEE, 8'h00);
			else begin
				e = exp_q.pop_front();
				if (e[9:8] == 2'd0) chk({7'h00, fetch_internal}, 8'h01);
				if (e[9:8] == 2'd1) chk(fetch_data, e[7:0]);
				if (e[9:8] == 2'd2) chk(data_rdata, e[7:0]);
			end
		end
	end
	// ------
	// main sequence
	// ------
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		repeat (6) @(posedge mclk);
		chk({7'h00, core_reset}, 8'h01);
		reset_standby_pin <= 0;
		for (k = 0; k < 10; k++) take(rnd(), 0, 0, 0, 0);
		chk({7'h00, core_reset}, 8'h00);
		fetch_select <= 1;
		take(16'h2222, 0, 0, 0, 0);
		for (k = 0; k < 5; k++) begin
			ad = k == 0 ? 16'h0000 : k == 1 ? 16'h0FFF : k == 2 ? 16'h1000 : k == 3 ? 16'hFFFF : rnd();
			take(ad, 0, 0, 0, 0);
		end
		for (k = 0; k < 8; k++) begin
			ad = k == 0 ? 16'hFFFF : rnd();
			p = rnd();
			take(16'h1234, 1, 1, ad, p);
			take(16'h1234, 1, 0, ad, 8'h00);
		end
		for (k = 0; k < 6; k++) begin
			port_three_latch <= rnd() | 8'hC0;
			port_three_alt_func_in <= rnd();
			{serial_sync_mode, serial_tx_data, serial_shift_clk} <= rnd();
			take(rnd(), 0, 0, 0, 0);
			take(rnd(), 0, 0, 0, 0);
			p = port_three_alt_func_in & port_three_latch;
			chk(port_three_alt_func_in_q, p);
			chk({count_in_one, count_in_zero, count_gate_one, ext_irq_one_n, count_gate_zero,
				ext_irq_zero_n, serial_rx_data, 1'b0},
				{p[5], p[4], p[3], p[3], p[2], p[2], p[0], 1'b0});
			chk(port_three_alt_func_out & ~port_three_latch, 8'h00);
			chk({7'h00, port_three_alt_func_out[1]}, {7'h00, port_three_latch[1]
				& (serial_sync_mode ? serial_shift_clk : serial_tx_data)});
		end
		chk({7'h00, exp_q.size() < 3}, 8'h01);
		stop_test();
	end
endmodule // embi_bus_tb
`default_nettype wire
